// File: verilog/dcg_pkg.sv
/*
 * Shared constants and types of the data collector glue block: header bytes,
 * trigger codes, control byte fields, transceiver levels and the state record.
 * Assumes one clock domain and an active-low asynchronous power-up reset.
 */
package dcg_pkg;

  // ****************************************
  // Sizes and counts
  // ****************************************
  localparam int DCG_DATA_W = 8;
  localparam int DCG_FIFO_DEPTH = 16;
  localparam int DCG_RST_CNT_W = 12;
  localparam logic [DCG_RST_CNT_W-1:0] DCG_RESET_COUNT = 12'h9C8;

  // ****************************************
  // Host header and control byte layout
  // ****************************************
  localparam logic [7:0] DCG_HDR_BYTE1 = 8'h5A;
  localparam logic [7:0] DCG_HDR_BYTE2 = 8'hC3;
  localparam logic [7:0] DCG_HDR_BYTE3 = 8'h7E;
  localparam int DCG_CTRL_START_BIT = 0;
  localparam int DCG_CTRL_LED_CLR_BIT = 2;
  localparam int DCG_CTRL_SW_CLR_BIT = 3;
  localparam int DCG_CTRL_LOOP_BIT = 4;

  // ****************************************
  // Trigger codes
  // ****************************************
  localparam logic [7:0] DCG_TRIG_SW1 = 8'h01;
  localparam logic [7:0] DCG_TRIG_SW2 = 8'h02;
  localparam logic [7:0] DCG_TRIG_SW_CLR = 8'h04;
  localparam logic [7:0] DCG_TRIG_NONE = 8'h00;
  localparam logic [3:0] DCG_LED0_CODE = 4'h1;
  localparam logic [3:0] DCG_LED1_CODE = 4'h2;
  localparam logic [3:0] DCG_LED2_CODE = 4'h4;
  localparam logic DCG_LED_ON = 1'b0;

  // ****************************************
  // Transceiver levels
  // ****************************************
  localparam logic DCG_DIR_B_TO_A = 1'b0;
  localparam logic DCG_OE_ON = 1'b0;
  localparam logic DCG_OE_OFF = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR_FIRST_SEEN = 2'b01,
    ST_HDR_SECOND_SEEN = 2'b10,
    ST_DECODE = 2'b11
  } dcg_hdr_e;

  typedef struct packed {
    logic valid;
    logic [DCG_DATA_W-1:0] data;
  } dcg_byte_s;

  typedef struct packed {
    logic [DCG_RST_CNT_W-1:0] rst_cnt;
    logic run;
    logic strobe_m;
    logic strobe_s;
    logic [DCG_DATA_W-1:0] port_m;
    logic [DCG_DATA_W-1:0] port_s;
    logic [1:0] btn_m;
    logic [1:0] btn_s;
    logic [7:0] trigger;
    logic latch;
    logic start;
    logic [DCG_DATA_W-1:0] xfer_byte;
    logic xcvr_dir;
    logic xcvr_oe_n;
    logic rx_seen;
    dcg_hdr_e hdr;
    logic [7:0] ctrl;
    logic [2:0] led_oe;
  } dcg_state_s;

endpackage

// File: verilog/dcg_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module dcg_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic in_valid_i, // Write request
  input wire logic [W-1:0] in_data_i, // Write data
  output logic in_ready_o, // Room for a word
  output logic out_valid_o, // Word available
  output logic [W-1:0] out_data_o, // Head word
  input wire logic out_ready_i // Drain side takes head
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_s;

  fifo_state_s r;
  fifo_state_s n;
  logic full;
  logic empty;

  assign empty = (r.wr == r.rd);
  assign full = (r.wr[AW-1:0] == r.rd[AW-1:0]) && (r.wr[AW] != r.rd[AW]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = r.mem[r.rd[AW-1:0]];

  always_comb begin
    n = r;
    if (in_valid_i && !full) begin
      n.mem[r.wr[AW-1:0]] = in_data_i;
      n.wr = r.wr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      n.rd = r.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// File: verilog/dcg_top.sv
/*
 * Data collector glue: power-up reset delay, LED and trigger handling,
 * strobe capture of the upper port into a FIFO toward the host, transceiver
 * control and the header-guarded host control byte.
 * Assumes host-side inputs are on clk_i; pins are asynchronous and synchronised.
 */
`timescale 1ns/1ps
module dcg_top #(
  parameter logic [dcg_pkg::DCG_RST_CNT_W-1:0] RESET_COUNT = dcg_pkg::DCG_RESET_COUNT,
  parameter int FIFO_DEPTH = dcg_pkg::DCG_FIFO_DEPTH
) (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Power-up reset, active low
  input wire logic write_strobe_i, // Partner write strobe pin
  input wire logic [dcg_pkg::DCG_DATA_W-1:0] upper_data_port_i, // Partner data pins
  input wire logic push_button_one_n_i, // User button one, low pressed
  input wire logic push_button_two_n_i, // User button two, low pressed
  input wire logic [7:0] host_trigger_byte_i, // Trigger byte from host
  input wire dcg_pkg::dcg_byte_s host_rx_byte_i, // Byte received from host
  output logic [7:0] trigger_to_host_o, // Trigger byte to host
  output logic transfer_start_o, // One-clock transfer start
  output logic [dcg_pkg::DCG_DATA_W-1:0] xfer_byte_o, // Outgoing byte register
  output dcg_pkg::dcg_byte_s host_tx_o, // Queued byte toward host
  input wire logic host_tx_ready_i, // Host side takes queued byte
  output logic [2:0] led_o, // LED pin values
  output logic [2:0] led_oe_o, // LED pin drive enables
  output logic enable_indicator_o, // Collection enabled LED, low on
  output logic xcvr1_direction_o, // Transceiver one direction
  output logic xcvr1_output_enable_n_o, // Transceiver one enable, low on
  output logic start_stop_o, // Start/stop level to partner
  output logic led_clear_o, // Control: LED clear
  output logic switch_clear_o, // Control: switch clear
  output logic loopback_o, // Control: loopback
  output logic internal_rst_n_o // Delayed internal reset, low active
);
  import dcg_pkg::*;

  // ****************************************
  // State
  // ****************************************
  dcg_state_s r;
  dcg_state_s n;
  logic new_byte;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DCG_DATA_W-1:0] fifo_out_data;

  // Receive indication is a level; one step per rising edge of it
  assign new_byte = host_rx_byte_i.valid && !r.rx_seen;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = r;
    n.strobe_m = write_strobe_i;
    n.strobe_s = r.strobe_m;
    n.port_m = upper_data_port_i;
    n.port_s = r.port_m;
    n.btn_m = {push_button_two_n_i, push_button_one_n_i};
    n.btn_s = r.btn_m;
    if (!r.run) begin
      n.trigger = DCG_TRIG_NONE;
      n.latch = 1'b0;
      n.start = 1'b0;
      n.xfer_byte = '0;
      n.xcvr_dir = DCG_DIR_B_TO_A;
      n.xcvr_oe_n = DCG_OE_ON;
      n.rx_seen = 1'b0;
      n.hdr = ST_IDLE;
      n.ctrl = '0;
      n.led_oe = '0;
      if (r.rst_cnt < RESET_COUNT) begin
        n.rst_cnt = r.rst_cnt + 1'b1;
      end else begin
        n.run = 1'b1;
      end
    end else begin
      // Trigger byte toward host, fixed priority
      if (!r.btn_s[0]) begin
        n.trigger = DCG_TRIG_SW1;
      end else if (!r.btn_s[1]) begin
        n.trigger = DCG_TRIG_SW2;
      end else if (r.ctrl[DCG_CTRL_SW_CLR_BIT]) begin
        n.trigger = DCG_TRIG_SW_CLR;
      end else begin
        n.trigger = DCG_TRIG_NONE;
      end

      // Strobe capture; waits while the FIFO is full, byte is lost if the strobe falls first
      n.start = 1'b0;
      if (r.strobe_s && !r.latch) begin
        if (fifo_in_ready) begin
          n.latch = 1'b1;
          n.start = 1'b1;
          n.xfer_byte = r.port_s;
        end
      end else if (!r.strobe_s && r.latch) begin
        n.latch = 1'b0;
        n.xfer_byte = '0;
      end

      // Shared port: float while partner drives or while stopped, drive only while started
      if (r.strobe_s) begin
        n.xcvr_oe_n = DCG_OE_OFF;
      end else if (r.ctrl[DCG_CTRL_START_BIT]) begin
        n.xcvr_oe_n = DCG_OE_ON;
      end else begin
        n.xcvr_oe_n = DCG_OE_OFF;
      end

      // Header guarded control byte
      n.rx_seen = host_rx_byte_i.valid;
      if (new_byte) begin
        unique case (r.hdr)
          ST_IDLE: begin
            n.hdr = (host_rx_byte_i.data == DCG_HDR_BYTE1) ? ST_HDR_FIRST_SEEN : ST_IDLE;
          end
          ST_HDR_FIRST_SEEN: begin
            n.hdr = (host_rx_byte_i.data == DCG_HDR_BYTE2) ? ST_HDR_SECOND_SEEN : ST_IDLE;
          end
          ST_HDR_SECOND_SEEN: begin
            n.hdr = (host_rx_byte_i.data == DCG_HDR_BYTE3) ? ST_DECODE : ST_IDLE;
          end
          ST_DECODE: begin
            n.ctrl = host_rx_byte_i.data;
            n.hdr = ST_IDLE;
          end
        endcase
      end

      // LEDs: a lit LED stays lit until LED clear or reset
      if (r.ctrl[DCG_CTRL_LED_CLR_BIT]) begin
        n.led_oe = '0;
      end else begin
        unique case (host_trigger_byte_i[3:0])
          DCG_LED0_CODE: n.led_oe[0] = 1'b1;
          DCG_LED1_CODE: n.led_oe[1] = 1'b1;
          DCG_LED2_CODE: n.led_oe[2] = 1'b1;
          default: n.led_oe = r.led_oe;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outbound byte queue
  // ****************************************
  // Each start pulse pushes the captured byte toward the host
  dcg_fifo #(
    .W(DCG_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(r.start),
    .in_data_i(r.xfer_byte),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(host_tx_ready_i)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign host_tx_o.valid = fifo_out_valid;
  assign host_tx_o.data = fifo_out_data;
  assign trigger_to_host_o = r.trigger;
  assign transfer_start_o = r.start;
  assign xfer_byte_o = r.xfer_byte;
  assign led_o = {3{DCG_LED_ON}};
  assign led_oe_o = r.led_oe;
  assign enable_indicator_o = ~r.ctrl[DCG_CTRL_START_BIT];
  assign xcvr1_direction_o = r.xcvr_dir;
  assign xcvr1_output_enable_n_o = r.xcvr_oe_n;
  assign start_stop_o = r.ctrl[DCG_CTRL_START_BIT];
  assign led_clear_o = r.ctrl[DCG_CTRL_LED_CLR_BIT];
  assign switch_clear_o = r.ctrl[DCG_CTRL_SW_CLR_BIT];
  assign loopback_o = r.ctrl[DCG_CTRL_LOOP_BIT];
  assign internal_rst_n_o = r.run;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence strobe_accept_s;
    r.run && r.strobe_s && !r.latch && fifo_in_ready;
  endsequence

  sequence strobe_release_s;
    r.run && !r.strobe_s && r.latch;
  endsequence

  sequence hdr_second_bad_s;
    r.run && new_byte && r.hdr == ST_HDR_FIRST_SEEN && host_rx_byte_i.data != DCG_HDR_BYTE2;
  endsequence

  sequence hdr_third_bad_s;
    r.run && new_byte && r.hdr == ST_HDR_SECOND_SEEN && host_rx_byte_i.data != DCG_HDR_BYTE3;
  endsequence

  sequence hdr_first_ok_s;
    r.run && new_byte && r.hdr == ST_IDLE && host_rx_byte_i.data == DCG_HDR_BYTE1;
  endsequence

  // Full queue: strobe seen but capture must wait
  sequence strobe_stall_s;
    r.run && r.strobe_s && !r.latch && !fifo_in_ready;
  endsequence

  reset_delay_hold_a: assert property (
    (r.rst_cnt < RESET_COUNT) |-> !r.run)
    else $error("internal reset released before threshold");

  xcvr_reset_a: assert property (
    !r.run |-> (r.xcvr_dir == DCG_DIR_B_TO_A && r.xcvr_oe_n == DCG_OE_ON))
    else $error("transceiver not B to A and enabled during reset");

  trigger_prio_a: assert property (
    (r.run && !r.btn_s[0]) |=> (r.trigger == DCG_TRIG_SW1))
    else $error("button one trigger code wrong");

  capture_pulse_a: assert property (
    strobe_accept_s |=> (r.start && r.latch && r.xfer_byte == $past(r.port_s)) ##1 !r.start)
    else $error("strobe capture or single pulse wrong");

  release_clear_a: assert property (
    strobe_release_s |=> (!r.latch && !r.start && r.xfer_byte == '0))
    else $error("strobe release did not clear latch and byte");

  port_float_a: assert property (
    (r.run && r.strobe_s) |=> (r.xcvr_oe_n == DCG_OE_OFF))
    else $error("shared port driven while strobe high");

  hdr_abort_a: assert property (
    hdr_second_bad_s |=> (r.hdr == ST_IDLE))
    else $error("bad second header byte did not abort");

  hdr_hold_a: assert property (
    (r.run && !new_byte) |=> $stable(r.hdr))
    else $error("header state moved without a new byte");

  decode_idle_a: assert property (
    (r.run && new_byte && r.hdr == ST_DECODE) |=>
      (r.hdr == ST_IDLE && start_stop_o == $past(host_rx_byte_i.data[DCG_CTRL_START_BIT])))
    else $error("control byte decode wrong");

  led_clear_a: assert property (
    (r.run && r.ctrl[DCG_CTRL_LED_CLR_BIT]) |=> (r.led_oe == '0))
    else $error("LEDs not floated on clear");

  reset_release_a: assert property (
    (!r.run && r.rst_cnt == RESET_COUNT) |=> r.run)
    else $error("internal reset not released at threshold");

  reset_count_a: assert property (
    (!r.run && r.rst_cnt < RESET_COUNT) |=> (r.rst_cnt == $past(r.rst_cnt) + 1'b1))
    else $error("reset counter did not step");

  trig_second_a: assert property (
    (r.run && r.btn_s[0] && !r.btn_s[1]) |=> (r.trigger == DCG_TRIG_SW2))
    else $error("button two trigger code wrong");

  trig_clear_a: assert property (
    (r.run && &r.btn_s && r.ctrl[DCG_CTRL_SW_CLR_BIT]) |=> (r.trigger == DCG_TRIG_SW_CLR))
    else $error("switch clear trigger code wrong");

  trig_none_a: assert property (
    (r.run && &r.btn_s && !r.ctrl[DCG_CTRL_SW_CLR_BIT]) |=> (r.trigger == DCG_TRIG_NONE))
    else $error("idle trigger code not zero");

  trig_reset_a: assert property (
    !r.run |-> (r.trigger == DCG_TRIG_NONE))
    else $error("trigger code not zero in reset");

  hdr_third_a: assert property (
    hdr_third_bad_s |=> (r.hdr == ST_IDLE))
    else $error("bad third header byte did not abort");

  hdr_first_a: assert property (
    hdr_first_ok_s |=> (r.hdr == ST_HDR_FIRST_SEEN))
    else $error("first header byte not taken");

  ctrl_guard_a: assert property (
    (r.run && !(new_byte && r.hdr == ST_DECODE)) |=> $stable(r.ctrl))
    else $error("control changed outside decode");

  led_set_zero_a: assert property (
    (r.run && !r.ctrl[DCG_CTRL_LED_CLR_BIT] && host_trigger_byte_i[3:0] == DCG_LED0_CODE) |=> r.led_oe[0])
    else $error("first LED not lit");

  led_set_one_a: assert property (
    (r.run && !r.ctrl[DCG_CTRL_LED_CLR_BIT] && host_trigger_byte_i[3:0] == DCG_LED1_CODE) |=> r.led_oe[1])
    else $error("second LED not lit");

  led_set_two_a: assert property (
    (r.run && !r.ctrl[DCG_CTRL_LED_CLR_BIT] && host_trigger_byte_i[3:0] == DCG_LED2_CODE) |=> r.led_oe[2])
    else $error("third LED not lit");

  led_reset_a: assert property (
    !r.run |-> (r.led_oe == '0))
    else $error("LEDs driven during reset");

  capture_stall_a: assert property (
    strobe_stall_s |=> (!r.start && !r.latch))
    else $error("capture taken while queue full");

  port_drive_a: assert property (
    (r.run && !r.strobe_s && r.ctrl[DCG_CTRL_START_BIT]) |=> (r.xcvr_oe_n == DCG_OE_ON))
    else $error("start level not driven to partner");

  push_room_a: assert property (
    r.start |-> fifo_in_ready)
    else $error("start pulse with no room in queue");

  start_single_a: assert property (
    r.start |=> !r.start)
    else $error("start pulse longer than one clock");
endmodule

// File: test/dcg_partner.sv
/*
 * Far-side model: the microcontroller strobe port and the host transfer side.
 * Assumes its tasks are called at falling clock edges.
 */
`timescale 1ns/1ps
module dcg_partner (
  input wire logic clk_i, // Clock
  input wire logic oe_n_i, // Shared port enable, low on
  output logic strobe_o, // Write strobe
  output logic [7:0] port_o, // Data pins
  output logic ready_o, // Host takes queued bytes
  output dcg_pkg::dcg_byte_s rx_o // Byte toward the device
);
  import dcg_pkg::*;
  logic oe_seen;
  initial begin
    strobe_o = 1'b0;
    port_o = 8'hFF;
    ready_o = 1'b0;
    rx_o = '0;
    oe_seen = 1'b0;
  end
  // Data settles a cycle before the strobe rises
  task automatic strobe_up(input logic [7:0] d);
    port_o = d;
    @(negedge clk_i);
    strobe_o = 1'b1;
  endtask
  task automatic strobe_down();
    oe_seen = oe_n_i;
    strobe_o = 1'b0;
    port_o = ~port_o; // Released pins show no stale value
    repeat (4) @(negedge clk_i);
  endtask
  task automatic mcu_write(input logic [7:0] d);
    strobe_up(d);
    repeat (5) @(negedge clk_i); // Well over two clocks
    strobe_down();
  endtask
  // Host side drains queued bytes when ready
  task automatic set_ready(input logic r);
    ready_o = r;
  endtask
  task automatic host_send(input logic [7:0] d);
    rx_o = '{valid: 1'b1, data: d};
    repeat (3) @(negedge clk_i);
    rx_o = '{valid: 1'b0, data: ~d};
    repeat (2) @(negedge clk_i);
  endtask
endmodule

// File: test/data_collector_glue_bench.sv
/*
 * Bench for the glue block: reset delay, LEDs, control header, strobe capture,
 * FIFO toward the host and trigger priority.
 * Assumes the far-side model dcg_partner.
 */
`timescale 1ns/1ps
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin errors++; $display("Error %0t: %s", $time, m); end end
module data_collector_glue_bench;
  import dcg_pkg::*;
  logic clk, nrst, b1_n, b2_n;
  logic [7:0] trig_host;
  int errors, checked, cycles, k, starts;
  logic [7:0] sent[$];
  logic [7:0] popped[$];
  logic [7:0] codes[4] = '{8'h01, 8'h03, 8'hA2, 8'h04};
  logic [2:0] exp_oe[4] = '{3'h1, 3'h1, 3'h3, 3'h7};
  logic strobe, ready, oe_n, start, ind, dir, irst, ss, lc, sc, lb;
  logic [7:0] port, trig_o, xbyte;
  logic [2:0] led, led_oe;
  dcg_byte_s rx, tx;
  dcg_top #(.RESET_COUNT(12'h008)) dut (.clk_i(clk), .nrst_i(nrst), .write_strobe_i(strobe),
    .upper_data_port_i(port), .push_button_one_n_i(b1_n), .push_button_two_n_i(b2_n),
    .host_trigger_byte_i(trig_host), .host_rx_byte_i(rx), .trigger_to_host_o(trig_o), .transfer_start_o(start),
    .xfer_byte_o(xbyte), .host_tx_o(tx), .host_tx_ready_i(ready), .led_o(led), .led_oe_o(led_oe),
    .enable_indicator_o(ind), .xcvr1_direction_o(dir), .xcvr1_output_enable_n_o(oe_n), .start_stop_o(ss),
    .led_clear_o(lc), .switch_clear_o(sc), .loopback_o(lb), .internal_rst_n_o(irst));
  dcg_partner partner (.clk_i(clk), .oe_n_i(oe_n), .strobe_o(strobe), .port_o(port), .ready_o(ready), .rx_o(rx));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Sampled mid-cycle, well clear of both edges
  always begin
    @(negedge clk);
    #1;
    if (start === 1'b1) begin
      starts++;
      `CHK(xbyte, sent[starts-1], "captured byte")
    end
    if (tx.valid === 1'b1 && ready === 1'b1) popped.push_back(tx.data);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("Error %0t: timeout", $time);
      conclude();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic ctrl(input logic [7:0] a, b, c, d, input logic [3:0] exp);
    partner.host_send(a);
    partner.host_send(b);
    partner.host_send(c);
    partner.host_send(d);
    `CHK({lb, sc, lc, ss}, exp, "control bits")
  endtask
  task automatic trig(input logic p1, p2, input logic [7:0] exp);
    b1_n = p1;
    b2_n = p2;
    repeat (5) @(negedge clk);
    `CHK(trig_o, exp, "trigger code")
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    b1_n = 1'b1;
    b2_n = 1'b1;
    trig_host = 8'h00;
    repeat (20) @(negedge clk);
    `CHK(irst, 1'b0, "internal reset held")
    `CHK(dir, DCG_DIR_B_TO_A, "direction in reset")
    `CHK(oe_n, DCG_OE_ON, "port on in reset")
    `CHK(led_oe, 3'h0, "LEDs float in reset")
    `CHK(ind, 1'b1, "indicator in reset")
    nrst = 1'b1;
    k = 0;
    while (irst !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    `CHK(k, 9, "reset release delay")
    $display("Test reset done");
    foreach (codes[i]) begin
      trig_host = codes[i];
      @(negedge clk);
      trig_host = 8'h00;
      repeat (2) @(negedge clk);
      `CHK(led_oe, exp_oe[i], "LED drive")
    end
    `CHK(led, {3{DCG_LED_ON}}, "LED level")
    ctrl(8'h5A, 8'hC3, 8'h7E, 8'h04, 4'h2);
    `CHK(led_oe, 3'h0, "LED clear floats")
    $display("Test LEDs done");
    ctrl(8'h5A, 8'hC3, 8'h7E, 8'h01, 4'h1);
    `CHK(ind, 1'b0, "indicator on")
    `CHK(oe_n, DCG_OE_ON, "start level driven")
    ctrl(8'h5A, 8'h11, 8'h7E, 8'h00, 4'h1);
    ctrl(8'h5A, 8'hC3, 8'h22, 8'h00, 4'h1);
    ctrl(8'h5A, 8'hC3, 8'h7E, 8'h1D, 4'hF);
    partner.host_send(8'h00);
    `CHK({lb, sc, lc, ss}, 4'hF, "byte after decode")
    $display("Test control done");
    trig(1'b1, 1'b1, DCG_TRIG_SW_CLR);
    trig(1'b1, 1'b0, DCG_TRIG_SW2);
    trig(1'b0, 1'b0, DCG_TRIG_SW1);
    trig(1'b0, 1'b1, DCG_TRIG_SW1);
    ctrl(8'h5A, 8'hC3, 8'h7E, 8'h01, 4'h1);
    trig(1'b1, 1'b1, DCG_TRIG_NONE);
    $display("Test triggers done");
    for (int i = 0; i < 16; i++) begin
      sent.push_back(8'hA0 + 8'(i));
      partner.mcu_write(sent[i]);
      `CHK(starts, i + 1, "one start per strobe")
      `CHK(xbyte, 8'h00, "byte cleared on fall")
      `CHK(partner.oe_seen, DCG_OE_OFF, "port floated")
      `CHK(oe_n, DCG_OE_ON, "port back on")
    end
    sent.push_back(8'h5C);
    partner.strobe_up(8'h5C);
    repeat (6) @(negedge clk);
    `CHK(starts, 16, "full FIFO stalls")
    partner.set_ready(1'b1);
    repeat (4) @(negedge clk);
    `CHK(starts, 17, "capture after room")
    partner.strobe_down();
    repeat (20) @(negedge clk);
    `CHK(popped.size(), 17, "bytes drained")
    foreach (popped[i]) `CHK(popped[i], sent[i], "drain order")
    `CHK(tx.valid, 1'b0, "FIFO empty")
    $display("Test capture done");
    ctrl(8'h5A, 8'hC3, 8'h7E, 8'hE2, 4'h0);
    `CHK(oe_n, DCG_OE_OFF, "port off when stopped")
    `CHK(ind, 1'b1, "indicator off")
    $display("Test stop done");
    conclude();
  end
endmodule
